// file: common/clk_switch_pkg.sv
package clk_switch_pkg;

   // Clock of the controller itself, in kHz, and the times it counts.
   localparam int unsigned MCLK_KHZ = 125000;
   localparam int unsigned DEBOUNCE_MS = 10;
   // The LED toggles twice per period, so each interval is half a period.
   localparam int unsigned BLINK_PERIOD_FAST_MS = 500;
   localparam int unsigned BLINK_PERIOD_MAIN_MS = 1000;
   localparam int unsigned BLINK_PERIOD_SUB_MS = 2000;
   localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * MCLK_KHZ;
   localparam int unsigned HALF_FAST_CYC = BLINK_PERIOD_FAST_MS * MCLK_KHZ / 2;
   localparam int unsigned HALF_MAIN_CYC = BLINK_PERIOD_MAIN_MS * MCLK_KHZ / 2;
   localparam int unsigned HALF_SUB_CYC = BLINK_PERIOD_SUB_MS * MCLK_KHZ / 2;

   // Register byte addresses.
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] STATE_ADDR = 8'h04;
   localparam logic [7:0] IRQ_STATUS_ADDR = 8'h08;
   localparam logic [7:0] IRQ_MASK_ADDR = 8'h0c;
   localparam logic [7:0] SWITCH_COUNT_ADDR = 8'h10;

   // Field positions and reset values.
   localparam int CTRL_ENABLE_BIT = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam int IRQ_SWITCHED_BIT = 0;
   localparam int IRQ_BLINK_BIT = 1;
   localparam int IRQ_REJECT_BIT = 2;
   localparam int IRQ_WIDTH = 3;
   localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

   typedef enum logic [1:0] {
      SRC_FAST = 2'h0,
      SRC_MAIN = 2'h1,
      SRC_SUB = 2'h2
   } clk_src_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;

   typedef struct packed {
      logic internal_fast_osc;
      logic main_crystal_osc;
      logic sub_crystal_osc;
   } osc_en_t;

endpackage : clk_switch_pkg

// file: rtl/button_clock_switcher.sv
// Contract
// - Each accepted press steps source: fast, main crystal, sub crystal, fast.
// - Source changes only after a detected press; otherwise it holds.
// - Switch level is checked after a debounced button interrupt event or after a blink interval event.
// - After a status change to the fast oscillator, stop main crystal.
// - After a status change to main crystal, stop the fast oscillator.
// - After a status change to sub crystal, stop main and fast.
// - The sub crystal oscillator keeps running at all times.
// - LED period is 0.5 s fast, 1 s main, 2 s sub.
// - LED toggles at each blink interval of the active source.
// - Oscillators are stopped only when status differs from last seen.
// - Initialise everything first, then enable interrupt handling.
// - Without a detected press, enter halt instead of switching.
// - Halt ends on a blink interval event or button interrupt.
// - After halt, check switch again and repeat the sequence.
// - The second LED output stays off permanently.
// - A debounce wait follows a button event before it is accepted.
`timescale 1ns/1ns
module button_clock_switcher #(
   parameter int unsigned DEBOUNCE_CYC = clk_switch_pkg::DEBOUNCE_CYC,
   parameter int unsigned HALF_FAST_CYC = clk_switch_pkg::HALF_FAST_CYC,
   parameter int unsigned HALF_MAIN_CYC = clk_switch_pkg::HALF_MAIN_CYC,
   parameter int unsigned HALF_SUB_CYC = clk_switch_pkg::HALF_SUB_CYC
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire clk_switch_pkg::apb_req_t apb_req,
   output clk_switch_pkg::apb_rsp_t apb_rsp,
   input wire logic button_input_pin_n,
   input wire logic main_crystal_ready,
   input wire logic sub_crystal_ready,
   output clk_switch_pkg::clk_src_t system_clock_sel,
   output clk_switch_pkg::osc_en_t osc_en,
   output logic led_output_pin,
   output logic spare_led_pin,
   output logic irq
);

   typedef enum {
      ST_INIT, ST_HALT, ST_DEBOUNCE, ST_CHECK, ST_SWITCH, ST_STATUS,
      ST_PERIOD
   } state_t;

   state_t state;
   logic [1:0] btn_sync;
   logic [1:0] main_sync;
   logic [1:0] sub_sync;
   logic btn_prev;
   logic btn_fall;
   logic irq_on;
   logic btn_pending;
   logic [31:0] wait_cnt;
   logic [31:0] blink_cnt;
   logic [31:0] blink_half;
   logic blink_evt;
   clk_switch_pkg::clk_src_t target;
   clk_switch_pkg::clk_src_t seen_src;
   logic [31:0] ctrl;
   logic [2:0] irq_status;
   logic [2:0] irq_mask;
   logic [15:0] switch_count;
   logic ev_switched;
   logic ev_reject;
   logic bus_write;
   logic pressed;

   function automatic clk_switch_pkg::clk_src_t next_src(
      input clk_switch_pkg::clk_src_t src);
      case (src)
         clk_switch_pkg::SRC_FAST: next_src = clk_switch_pkg::SRC_MAIN;
         clk_switch_pkg::SRC_MAIN: next_src = clk_switch_pkg::SRC_SUB;
         default: next_src = clk_switch_pkg::SRC_FAST;
      endcase
   endfunction : next_src

   function automatic logic [31:0] half_period(
      input clk_switch_pkg::clk_src_t src);
      case (src)
         clk_switch_pkg::SRC_FAST: half_period = HALF_FAST_CYC;
         clk_switch_pkg::SRC_MAIN: half_period = HALF_MAIN_CYC;
         default: half_period = HALF_SUB_CYC;
      endcase
   endfunction : half_period

   // Pins from the board are synchronised before use.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         btn_sync <= 2'h3;
         main_sync <= 2'h0;
         sub_sync <= 2'h0;
         btn_prev <= 1'b1;
      end else begin
         btn_sync <= {btn_sync[0], button_input_pin_n};
         main_sync <= {main_sync[0], main_crystal_ready};
         sub_sync <= {sub_sync[0], sub_crystal_ready};
         btn_prev <= btn_sync[1];
      end
   end

   assign pressed = !btn_sync[1];
   // A falling edge of the switch is the button interrupt event.
   assign btn_fall = btn_prev && pressed && irq_on && ctrl[0];
   assign bus_write = apb_req.psel && apb_req.penable && apb_req.pwrite
      && apb_rsp.pready;

   // Main sequence: halt, debounce, check, switch, status, period.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_INIT;
         irq_on <= 1'b0;
         wait_cnt <= 32'h0;
         target <= clk_switch_pkg::SRC_FAST;
         system_clock_sel <= clk_switch_pkg::SRC_FAST;
         btn_pending <= 1'b0;
      end else begin
         if (btn_fall) begin
            btn_pending <= 1'b1;
         end
         case (state)
            ST_INIT: begin
               irq_on <= 1'b1;
               state <= ST_HALT;
            end
            ST_HALT: begin
               if (btn_fall || btn_pending) begin
                  wait_cnt <= 32'h0;
                  state <= ST_DEBOUNCE;
               end else if (blink_evt) begin
                  state <= ST_CHECK;
               end
            end
            ST_DEBOUNCE: begin
               wait_cnt <= wait_cnt + 32'h1;
               if (wait_cnt >= DEBOUNCE_CYC - 1) begin
                  state <= ST_CHECK;
               end
            end
            ST_CHECK: begin
               btn_pending <= btn_fall;
               if (btn_pending && pressed) begin
                  target <= next_src(system_clock_sel);
                  state <= ST_SWITCH;
               end else begin
                  state <= ST_HALT;
               end
            end
            ST_SWITCH: begin
               if (target == clk_switch_pkg::SRC_FAST
                  || (target == clk_switch_pkg::SRC_MAIN && main_sync[1])
                  || (target == clk_switch_pkg::SRC_SUB && sub_sync[1])) begin
                  system_clock_sel <= target;
                  state <= ST_STATUS;
               end
            end
            ST_STATUS: state <= ST_PERIOD;
            ST_PERIOD: state <= ST_HALT;
            default: state <= ST_HALT;
         endcase
      end
   end

   // Oscillator enables; the main crystal is started before it is selected, the fast oscillator in the same cycle.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         osc_en <= '{internal_fast_osc: 1'b1, main_crystal_osc: 1'b0,
            sub_crystal_osc: 1'b1};
         seen_src <= clk_switch_pkg::SRC_FAST;
         ev_switched <= 1'b0;
      end else begin
         ev_switched <= 1'b0;
         osc_en.sub_crystal_osc <= 1'b1;
         if (state == ST_SWITCH && target == clk_switch_pkg::SRC_FAST) begin
            osc_en.internal_fast_osc <= 1'b1;
         end
         if (state == ST_SWITCH && target == clk_switch_pkg::SRC_MAIN) begin
            osc_en.main_crystal_osc <= 1'b1;
         end
         if (state == ST_STATUS && system_clock_sel != seen_src) begin
            seen_src <= system_clock_sel;
            ev_switched <= 1'b1;
            case (system_clock_sel)
               clk_switch_pkg::SRC_FAST: begin
                  osc_en.main_crystal_osc <= 1'b0;
               end
               clk_switch_pkg::SRC_MAIN: begin
                  osc_en.internal_fast_osc <= 1'b0;
               end
               default: begin
                  osc_en.main_crystal_osc <= 1'b0;
                  osc_en.internal_fast_osc <= 1'b0;
               end
            endcase
         end
      end
   end

   // Blink timer: the interval follows the selected source.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         blink_half <= HALF_FAST_CYC;
         blink_cnt <= 32'h0;
         blink_evt <= 1'b0;
         led_output_pin <= 1'b0;
         spare_led_pin <= 1'b0;
      end else begin
         spare_led_pin <= 1'b0;
         blink_evt <= 1'b0;
         if (state == ST_PERIOD) begin
            blink_half <= half_period(system_clock_sel);
            blink_cnt <= 32'h0;
         end else if (state != ST_INIT && blink_cnt >= blink_half - 1) begin
            blink_cnt <= 32'h0;
            blink_evt <= 1'b1;
            led_output_pin <= !led_output_pin;
         end else begin
            blink_cnt <= blink_cnt + 32'h1;
         end
      end
   end

   // A press that fails the debounce check is reported as rejected.
   assign ev_reject = state == ST_CHECK && btn_pending && !pressed;

   // Sticky event bits; a new event wins over a clearing write.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         irq_status <= 3'h0;
         irq <= 1'b0;
      end else begin
         irq_status <= {ev_reject, blink_evt, ev_switched} | (irq_status
            & ~(bus_write && apb_req.paddr == clk_switch_pkg::IRQ_STATUS_ADDR
            ? apb_req.pwdata[2:0] : 3'h0));
         irq <= |(irq_status & irq_mask);
      end
   end

   // Writable registers and the switch counter.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ctrl <= clk_switch_pkg::CTRL_RESET;
         irq_mask <= clk_switch_pkg::IRQ_MASK_RESET;
         switch_count <= 16'h0;
      end else begin
         if (ev_switched) begin
            switch_count <= switch_count + 16'h1;
         end
         if (bus_write && apb_req.paddr == clk_switch_pkg::CTRL_ADDR) begin
            ctrl <= {31'h0, apb_req.pwdata[clk_switch_pkg::CTRL_ENABLE_BIT]};
         end
         if (bus_write && apb_req.paddr == clk_switch_pkg::IRQ_MASK_ADDR) begin
            irq_mask <= apb_req.pwdata[2:0];
         end
      end
   end

   // APB slave: no wait states, answer ready in the first access cycle.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         apb_rsp <= '0;
      end else begin
         apb_rsp.pready <= apb_req.psel && !apb_req.penable;
         apb_rsp.pslverr <= 1'b0;
         apb_rsp.prdata <= 32'h0;
         if (apb_req.psel && !apb_req.penable) begin
            case (apb_req.paddr)
               clk_switch_pkg::CTRL_ADDR: apb_rsp.prdata <= ctrl;
               clk_switch_pkg::STATE_ADDR: begin
                  apb_rsp.prdata <= {25'h0, osc_en, irq_on,
                     state == ST_HALT, system_clock_sel};
               end
               clk_switch_pkg::IRQ_STATUS_ADDR: begin
                  apb_rsp.prdata <= {29'h0, irq_status};
               end
               clk_switch_pkg::IRQ_MASK_ADDR: begin
                  apb_rsp.prdata <= {29'h0, irq_mask};
               end
               clk_switch_pkg::SWITCH_COUNT_ADDR: begin
                  apb_rsp.prdata <= {16'h0, switch_count};
               end
               default: apb_rsp.pslverr <= 1'b1;
            endcase
         end
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   sequence s_press_accepted;
      state == ST_CHECK && btn_pending && pressed;
   endsequence

   property p_step_order;
      s_press_accepted ##1 state == ST_SWITCH
         |-> target == next_src($past(system_clock_sel));
   endproperty
   a_step_order: assert property (p_step_order)
      else $error("clock source stepped out of order");

   property p_sel_only_on_switch;
      $changed(system_clock_sel) |-> $past(state) == ST_SWITCH;
   endproperty
   a_sel_only_on_switch: assert property (p_sel_only_on_switch)
      else $error("clock source changed without a press");

   property p_fast_stops_main;
      state == ST_STATUS && system_clock_sel == clk_switch_pkg::SRC_FAST
         && system_clock_sel != seen_src |=> !osc_en.main_crystal_osc;
   endproperty
   a_fast_stops_main: assert property (p_fast_stops_main)
      else $error("main crystal left running on fast source");

   property p_main_stops_fast;
      state == ST_STATUS && system_clock_sel == clk_switch_pkg::SRC_MAIN
         && system_clock_sel != seen_src |=> !osc_en.internal_fast_osc;
   endproperty
   a_main_stops_fast: assert property (p_main_stops_fast)
      else $error("fast oscillator left running on main crystal");

   property p_sub_stops_both;
      state == ST_STATUS && system_clock_sel == clk_switch_pkg::SRC_SUB
         && system_clock_sel != seen_src
         |=> !osc_en.internal_fast_osc && !osc_en.main_crystal_osc;
   endproperty
   a_sub_stops_both: assert property (p_sub_stops_both)
      else $error("oscillators left running on sub crystal");

   property p_sub_always;
      ##1 osc_en.sub_crystal_osc && !spare_led_pin;
   endproperty
   a_sub_always: assert property (p_sub_always)
      else $error("sub crystal stopped or spare LED lit");

   property p_period_load;
      state == ST_PERIOD |=> blink_half == half_period(system_clock_sel);
   endproperty
   a_period_load: assert property (p_period_load)
      else $error("blink interval does not match source");

   property p_led_toggle;
      blink_evt |-> led_output_pin != $past(led_output_pin);
   endproperty
   a_led_toggle: assert property (p_led_toggle)
      else $error("LED did not toggle on blink event");

   property p_no_press_halts;
      state == ST_CHECK && !(btn_pending && pressed) |=> state == ST_HALT;
   endproperty
   a_no_press_halts: assert property (p_no_press_halts)
      else $error("no press yet halt not entered");

   property p_debounce_wait;
      state == ST_HALT && (btn_fall || btn_pending)
         |=> state == ST_DEBOUNCE [*2];
   endproperty
   a_debounce_wait: assert property (p_debounce_wait)
      else $error("button event accepted without debounce");

   property p_crystal_ready;
      $changed(system_clock_sel)
         && system_clock_sel == clk_switch_pkg::SRC_MAIN
         |-> $past(main_sync[1]);
   endproperty
   a_crystal_ready: assert property (p_crystal_ready)
      else $error("main crystal selected before stable");

endmodule : button_clock_switcher

// file: dv/board_model.sv
`timescale 1ns/1ns
module board_model #(
   parameter int unsigned STARTUP_CYC = 12
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire clk_switch_pkg::osc_en_t osc_en,
   output logic button_input_pin_n,
   output logic main_crystal_ready,
   output logic sub_crystal_ready
);
   int unsigned main_age;
   int unsigned sub_age;

   // The switch has a pull-up, so an idle switch reads high.
   initial button_input_pin_n = 1'b1;

   // A crystal reports stable only after running for its start-up time,
   // and drops the flag as soon as it is stopped.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         main_age <= 0;
         sub_age <= 0;
      end else begin
         main_age <= osc_en.main_crystal_osc ? main_age + 1 : 0;
         sub_age <= osc_en.sub_crystal_osc ? sub_age + 1 : 0;
      end
   end
   assign main_crystal_ready = main_age >= STARTUP_CYC;
   assign sub_crystal_ready = sub_age >= STARTUP_CYC;

   task automatic press(input int unsigned hold);
      @(posedge mclk);
      button_input_pin_n <= 1'b0;
      repeat (hold) @(posedge mclk);
      button_input_pin_n <= 1'b1;
   endtask : press
endmodule : board_model

// file: dv/testbench.sv
`timescale 1ns/1ns
module testbench;
   localparam int unsigned DEB = 20;
   localparam int unsigned HF = 8;
   localparam int unsigned HM = 16;
   localparam int unsigned HS = 32;
   logic mclk;
   logic nrst;
   clk_switch_pkg::apb_req_t apb_req;
   clk_switch_pkg::apb_rsp_t apb_rsp;
   logic button_input_pin_n;
   logic main_crystal_ready;
   logic sub_crystal_ready;
   clk_switch_pkg::clk_src_t system_clock_sel;
   clk_switch_pkg::osc_en_t osc_en;
   logic led_output_pin;
   logic spare_led_pin;
   logic irq;
   int fail_count;
   int compares;
   logic [31:0] rd;
   logic err;
   int n;

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   button_clock_switcher #(
      .DEBOUNCE_CYC(DEB), .HALF_FAST_CYC(HF),
      .HALF_MAIN_CYC(HM), .HALF_SUB_CYC(HS)
   ) button_clock_switcher_i (
      .mclk(mclk), .nrst(nrst), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .button_input_pin_n(button_input_pin_n),
      .main_crystal_ready(main_crystal_ready),
      .sub_crystal_ready(sub_crystal_ready),
      .system_clock_sel(system_clock_sel), .osc_en(osc_en),
      .led_output_pin(led_output_pin), .spare_led_pin(spare_led_pin),
      .irq(irq)
   );

   board_model board_model_i (
      .mclk(mclk), .nrst(nrst), .osc_en(osc_en),
      .button_input_pin_n(button_input_pin_n),
      .main_crystal_ready(main_crystal_ready),
      .sub_crystal_ready(sub_crystal_ready)
   );

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic timed_out(input string name);
      fail_count++;
      $display("mismatch %s expected completion seen timeout", name);
      report_and_stop();
   endtask : timed_out

   // One APB transfer; read data and error land in rd and err.
   task automatic apb(input logic wr, input logic [7:0] addr,
                      input logic [31:0] wdata);
      int i;
      @(posedge mclk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr,
                   pwdata: wdata};
      @(posedge mclk);
      apb_req.penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge mclk);
         if (apb_rsp.pready === 1'b1) break;
      end
      if (i == 50) timed_out("pready");
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask : apb

   // Cycles between two LED toggles, skipping the first partial interval.
   task automatic half_period(output int cnt);
      logic prev;
      int k;
      for (k = 0; k < 2; k++) begin
         prev = led_output_pin;
         cnt = 0;
         while (led_output_pin === prev) begin
            @(posedge mclk);
            cnt++;
            if (cnt > 4 * HS) timed_out("led toggle");
         end
      end
   endtask : half_period

   task automatic step(input clk_switch_pkg::clk_src_t exp,
                       input logic [2:0] en, input int half,
                       input int count);
      int i;
      board_model_i.press(28);
      for (i = 0; i < 400; i++) begin
         @(posedge mclk);
         if (system_clock_sel === exp && osc_en === en) break;
      end
      if (i == 400) timed_out("clock switch");
      check("sel", system_clock_sel, exp);
      check("osc_en", osc_en, en);
      half_period(n);
      check("blink interval", n, half);
      apb(1'b0, clk_switch_pkg::STATE_ADDR, 32'h0);
      check("state sel", rd[1:0], exp);
      check("state osc", rd[6:4], en);
      apb(1'b0, clk_switch_pkg::SWITCH_COUNT_ADDR, 32'h0);
      check("switch count", rd[15:0], count);
      $display("test switch to %0d done", exp);
   endtask : step

   initial begin
      nrst = 1'b0;
      apb_req = '0;
      fail_count = 0;
      compares = 0;
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      check("sel", system_clock_sel, clk_switch_pkg::SRC_FAST);
      check("osc_en", osc_en, 3'h5);
      check("spare led", spare_led_pin, 1'b0);
      check("irq", irq, 1'b0);
      apb(1'b0, clk_switch_pkg::CTRL_ADDR, 32'h0);
      check("ctrl", rd, clk_switch_pkg::CTRL_RESET);
      apb(1'b0, clk_switch_pkg::IRQ_MASK_ADDR, 32'h0);
      check("mask", rd, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      check("unmapped err", err, 1'b1);
      check("unmapped data", rd, 32'h0);
      half_period(n);
      check("blink interval", n, HF);
      $display("test reset and registers done");
      step(clk_switch_pkg::SRC_MAIN, 3'h3, HM, 1);
      step(clk_switch_pkg::SRC_SUB, 3'h1, HS, 2);
      step(clk_switch_pkg::SRC_FAST, 3'h5, HF, 3);
      apb(1'b1, clk_switch_pkg::IRQ_STATUS_ADDR, 32'h7);
      apb(1'b1, clk_switch_pkg::IRQ_MASK_ADDR, 32'h4);
      apb(1'b0, clk_switch_pkg::IRQ_MASK_ADDR, 32'h0);
      check("mask", rd[2:0], 3'h4);
      check("irq", irq, 1'b0);
      board_model_i.press(5);
      repeat (DEB + 20) @(posedge mclk);
      check("sel", system_clock_sel, clk_switch_pkg::SRC_FAST);
      apb(1'b0, clk_switch_pkg::IRQ_STATUS_ADDR, 32'h0);
      check("reject bit", rd[2], 1'b1);
      check("irq", irq, 1'b1);
      apb(1'b1, clk_switch_pkg::IRQ_STATUS_ADDR, 32'h4);
      repeat (2) @(posedge mclk);
      check("irq", irq, 1'b0);
      apb(1'b0, clk_switch_pkg::IRQ_STATUS_ADDR, 32'h0);
      check("reject bit", rd[2], 1'b0);
      apb(1'b1, clk_switch_pkg::IRQ_MASK_ADDR, 32'h0);
      $display("test short press and interrupt done");
      apb(1'b1, clk_switch_pkg::CTRL_ADDR, 32'h0);
      board_model_i.press(28);
      repeat (DEB + 40) @(posedge mclk);
      check("sel", system_clock_sel, clk_switch_pkg::SRC_FAST);
      check("osc_en", osc_en, 3'h5);
      apb(1'b1, clk_switch_pkg::CTRL_ADDR, 32'h1);
      $display("test disabled events done");
      step(clk_switch_pkg::SRC_MAIN, 3'h3, HM, 4);
      report_and_stop();
   end

   initial begin
      repeat (100000) @(posedge mclk);
      timed_out("run length");
   end
endmodule : testbench
